// *** core/ccs_pkg.sv ***
/*
 Shared constants and carriers for the command and status logic of a
 stand-alone CAN controller. Assumes a protocol engine on the same clock.
*/
// Function
// - Command register always reads back as zero.
// - Self reception transmits and receives locally.
// - Clear-overrun command clears the overrun flag.
// - Release frees message; empty queue drops pending.
// - Abort cancels pending, not running, transmission.
// - Transmit request starts sending the buffer.
// - Request plus abort sends once, no retry.
// - Self reception plus abort sends once.
// - All three bits act as single-shot transmit.
// - Request plus self reception ignores self reception.
// - Held request clears when transmitting starts.
// - No new overrun event while flag set.
// - Abort still gives a transmit event.
// - Writing zero never withdraws a request.
// - Bus-off flag mirrors bus-off state.
// - Warning flag when a counter reaches limit.
// - Transmit and receive activity flags follow engine.
// - Done flag set after successful transmission.
// - Buffer free flag low while message queued.
// - Overrun flag sticky until clear command.
// - Pending flag while queue holds a message.
// - Done flag cleared when a request is set.
// - Buffer writes while locked are silently dropped.
// - Warning limit resets to 96.
package ccs_pkg;

    // ==========================================
    // Register indices (byte address = index * 4)
    localparam logic [5:0] CCS_IDX_CMD   = 6'h01;
    localparam logic [5:0] CCS_IDX_STATE = 6'h02;
    localparam logic [5:0] CCS_IDX_WARN  = 6'h06;

    // ==========================================
    // Command bit positions
    localparam int CCS_CMD_TXREQ   = 0;
    localparam int CCS_CMD_CANCEL  = 1;
    localparam int CCS_CMD_RELEASE = 2;
    localparam int CCS_CMD_CLROVR  = 3;
    localparam int CCS_CMD_SELFRX  = 4;

    // ==========================================
    // Reset values and responses
    localparam logic [7:0] CCS_WARN_RESET = 8'h60;
    localparam logic [1:0] CCS_RESP_OKAY  = 2'h0;
    localparam logic [1:0] CCS_RESP_SLVER = 2'h2;

    // ==========================================
    // Carriers
    typedef struct packed {
        logic       busOff;
        logic       txActive;
        logic       rxActive;
        logic       txFrameEnd;
        logic       txFrameOk;
        logic       rxMsgStored;
        logic       rxNoSpace;
        logic [7:0] txErrCount;
        logic [7:0] rxErrCount;
    } ccs_engine_t;

    typedef struct packed {
        logic txGo;
        logic singleShot;
        logic selfRx;
    } ccs_txctl_t;

endpackage

// *** core/can_command_status_logic.sv ***
/*
 Command strobe and controller state logic behind an AXI4-Lite slave.
 Assumes the protocol engine runs on the same clock and reports through
 the engine carrier; the receive queue itself lives in the engine.
*/
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ns
module can_command_status_logic #(
    parameter int QUEUE_MSGS = 21
) (
    // Clock and reset
    input  wire logic                clock,
    input  wire logic                arst_n,
    // AXI4-Lite write channels
    input  wire logic [7:0]          awaddr,
    input  wire logic                awvalid,
    output      logic                awready,
    input  wire logic [31:0]         wdata,
    input  wire logic [3:0]          wstrb,
    input  wire logic                wvalid,
    output      logic                wready,
    output      logic [1:0]          bresp,
    output      logic                bvalid,
    input  wire logic                bready,
    // AXI4-Lite read channels
    input  wire logic [7:0]          araddr,
    input  wire logic                arvalid,
    output      logic                arready,
    output      logic [31:0]         rdata,
    output      logic [1:0]          rresp,
    output      logic                rvalid,
    input  wire logic                rready,
    // Protocol engine
    input  wire ccs_pkg::ccs_engine_t engine,
    output      ccs_pkg::ccs_txctl_t  txCtl,
    output      logic                rxRelease,
    output      logic                txEvent,
    output      logic                overrunEvent,
    output      logic                rxPendingFlag,
    // Transmit buffer write gate
    input  wire logic                hostBufWe,
    output      logic                txBufWe
);
    import ccs_pkg::*;

    localparam int CNT_W = $clog2(QUEUE_MSGS + 1);

    // ==========================================
    // Internal clock enable at half rate
    logic tick;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            tick <= 1'b0;
        end else begin
            tick <= ~tick;
        end
    end

    // ==========================================
    // Write path
    logic [5:0]  awIdx;
    logic [31:0] wDataQ;
    logic        wLaneQ;
    logic        cmdPend;
    logic [4:0]  cmdBits;
    logic [7:0]  warnLimit;

    wire doWrite  = !awready && !wready && !bvalid && !cmdPend;
    wire wrCmd    = (awIdx == CCS_IDX_CMD);
    wire wrWarn   = (awIdx == CCS_IDX_WARN);
    wire wrState  = (awIdx == CCS_IDX_STATE);
    wire wrMapped = wrCmd || wrWarn || wrState;
    wire cmdFire  = tick && cmdPend;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            awready <= 1'b1;
            wready  <= 1'b1;
            awIdx   <= 6'h00;
            wDataQ  <= 32'h0000_0000;
            wLaneQ  <= 1'b0;
        end else begin
            if (awvalid && awready) begin
                awready <= 1'b0;
                awIdx   <= awaddr[7:2];
            end
            if (wvalid && wready) begin
                wready <= 1'b0;
                wDataQ <= wdata;
                wLaneQ <= wstrb[0];
            end
            if (bvalid && bready) begin
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // Command stays latched only until the next internal tick
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cmdPend <= 1'b0;
            cmdBits <= 5'h00;
        end else if (doWrite && wrCmd) begin
            cmdPend <= 1'b1;
            cmdBits <= wLaneQ ? wDataQ[4:0] : 5'h00;
        end else if (cmdFire) begin
            cmdPend <= 1'b0;
            cmdBits <= 5'h00;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            bvalid <= 1'b0;
            bresp  <= CCS_RESP_OKAY;
        end else if (cmdFire) begin
            bvalid <= 1'b1;
            bresp  <= CCS_RESP_OKAY;
        end else if (doWrite && !wrCmd) begin
            bvalid <= 1'b1;
            bresp  <= wrMapped ? CCS_RESP_OKAY : CCS_RESP_SLVER;
        end else if (bvalid && bready) begin
            bvalid <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            warnLimit <= CCS_WARN_RESET;
        end else if (doWrite && wrWarn && wLaneQ) begin
            warnLimit <= wDataQ[7:0];
        end
    end

    // ==========================================
    // Command decode
    wire cTx   = cmdFire && cmdBits[CCS_CMD_TXREQ];
    wire cAb   = cmdFire && cmdBits[CCS_CMD_CANCEL];
    wire cRel  = cmdFire && cmdBits[CCS_CMD_RELEASE];
    wire cClr  = cmdFire && cmdBits[CCS_CMD_CLROVR];
    wire cSrr  = cmdFire && cmdBits[CCS_CMD_SELFRX];
    wire start = cTx || cSrr;
    wire oneShot = start && cAb;
    wire selfOnly = cSrr && !cTx;
    wire cancel  = cAb && !start;

    // ==========================================
    // Transmit control
    logic txLocked;
    logic txDone;
    logic txActiveD;

    wire freeNow   = !txLocked;
    wire accept    = start && freeNow;
    wire txRise    = engine.txActive && !txActiveD;
    wire doCancel  = cancel && txCtl.txGo && !engine.txActive;
    wire endOk     = engine.txFrameEnd && engine.txFrameOk;
    wire endFail   = engine.txFrameEnd && !engine.txFrameOk;
    wire endLast   = endFail && txCtl.singleShot;
    wire retry     = endFail && !txCtl.singleShot;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            txActiveD <= 1'b0;
        end else begin
            txActiveD <= engine.txActive;
        end
    end

    // Only abort or the start of transmission drops a held request; a written zero does nothing
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            txCtl <= '0;
        end else if (accept) begin
            txCtl.txGo       <= 1'b1;
            txCtl.singleShot <= oneShot;
            txCtl.selfRx     <= selfOnly;
        end else if (doCancel) begin
            txCtl.txGo <= 1'b0;
        end else if (txRise) begin
            txCtl.txGo <= 1'b0;
        end else if (retry) begin
            txCtl.txGo <= 1'b1;
        end else if (cancel && engine.txActive) begin
            txCtl.singleShot <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            txLocked <= 1'b0;
        end else if (accept) begin
            txLocked <= 1'b1;
        end else if (doCancel || endOk || endLast) begin
            txLocked <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            txDone <= 1'b1;
        end else if (accept) begin
            txDone <= 1'b0;
        end else if (endOk) begin
            txDone <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            txEvent <= 1'b0;
            txBufWe <= 1'b0;
        end else begin
            txEvent <= doCancel || endOk || endLast;
            txBufWe <= hostBufWe && freeNow;
        end
    end

    // ==========================================
    // Receive queue bookkeeping
    logic [CNT_W-1:0] rxCount;
    logic             overrun;

    wire relOk = cRel && (rxCount != '0);
    wire incOk = engine.rxMsgStored && (rxCount != CNT_W'(QUEUE_MSGS));

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rxCount <= '0;
        end else if (incOk && !relOk) begin
            rxCount <= rxCount + CNT_W'(1);
        end else if (relOk && !incOk) begin
            rxCount <= rxCount - CNT_W'(1);
        end
    end

    wire [CNT_W-1:0] next_rxCount = (incOk && !relOk) ? rxCount + CNT_W'(1) :
                                    (relOk && !incOk) ? rxCount - CNT_W'(1) : rxCount;

    // Set wins over a clear in the same cycle
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            overrun <= 1'b0;
        end else if (engine.rxNoSpace) begin
            overrun <= 1'b1;
        end else if (cClr) begin
            overrun <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            overrunEvent  <= 1'b0;
            rxPendingFlag <= 1'b0;
            rxRelease     <= 1'b0;
        end else begin
            overrunEvent  <= engine.rxNoSpace && !overrun;
            rxPendingFlag <= (next_rxCount != '0);
            rxRelease     <= relOk;
        end
    end

    // ==========================================
    // Controller state flags
    logic busOffF;
    logic warnF;
    logic txActF;
    logic rxActF;

    wire warnHit = (engine.txErrCount >= warnLimit) || (engine.rxErrCount >= warnLimit);

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            busOffF <= 1'b0;
            warnF   <= 1'b0;
            txActF  <= 1'b0;
            rxActF  <= 1'b0;
        end else begin
            busOffF <= engine.busOff;
            warnF   <= warnHit;
            txActF  <= engine.txActive;
            rxActF  <= engine.rxActive;
        end
    end

    wire [7:0] stateByte = {busOffF, warnF, txActF, rxActF,
                            txDone, freeNow, overrun, rxPendingFlag};

    // ==========================================
    // Read path
    wire [5:0] arIdx    = araddr[7:2];
    wire       rdCmd    = (arIdx == CCS_IDX_CMD);
    wire       rdState  = (arIdx == CCS_IDX_STATE);
    wire       rdWarn   = (arIdx == CCS_IDX_WARN);
    wire [7:0] rdByte   = rdState ? stateByte : rdWarn ? warnLimit : 8'h00;
    wire       rdMapped = rdCmd || rdState || rdWarn;
    logic      rdWasCmd;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            arready  <= 1'b1;
            rvalid   <= 1'b0;
            rdata    <= 32'h0000_0000;
            rresp    <= CCS_RESP_OKAY;
            rdWasCmd <= 1'b0;
        end else if (arvalid && arready) begin
            arready  <= 1'b0;
            rvalid   <= 1'b1;
            rdata    <= {24'h00_0000, rdByte};
            rresp    <= rdMapped ? CCS_RESP_OKAY : CCS_RESP_SLVER;
            rdWasCmd <= rdCmd;
        end else if (rvalid && rready) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
        end
    end

    // ==========================================
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    property p_cmd_zero;
        rvalid && rdWasCmd |-> rdata == 32'h0000_0000;
    endproperty
    a_cmd_zero: assert property (p_cmd_zero) else $error("command read not zero");

    property p_fire_pulse;
        cmdFire |=> !cmdFire ##1 !cmdFire;
    endproperty
    a_fire_pulse: assert property (p_fire_pulse) else $error("command not single pulse");

    property p_req_clear;
        txCtl.txGo && txRise && !accept |=> !txCtl.txGo;
    endproperty
    a_req_clear: assert property (p_req_clear) else $error("request not cleared at start");

    property p_start;
        accept |=> txCtl.txGo && !txDone && txLocked;
    endproperty
    a_start: assert property (p_start) else $error("request not taken");

    property p_cancel;
        doCancel |=> !txCtl.txGo && !txLocked && txEvent;
    endproperty
    a_cancel: assert property (p_cancel) else $error("abort mishandled");

    property p_self_ignored;
        accept && cTx |=> !txCtl.selfRx;
    endproperty
    a_self_ignored: assert property (p_self_ignored) else $error("self reception not ignored");

    property p_overrun_clear;
        cClr && !engine.rxNoSpace |=> !overrun;
    endproperty
    a_overrun_clear: assert property (p_overrun_clear) else $error("overrun not cleared");

    property p_overrun_sticky;
        overrun && !cClr |=> overrun && !overrunEvent;
    endproperty
    a_overrun_sticky: assert property (p_overrun_sticky) else $error("overrun event repeated");

    property p_release_last;
        relOk && rxCount == CNT_W'(1) && !engine.rxMsgStored |=> !rxPendingFlag;
    endproperty
    a_release_last: assert property (p_release_last) else $error("pending flag stuck");

    property p_warn;
        ##1 warnF == $past(warnHit);
    endproperty
    a_warn: assert property (p_warn) else $error("warning flag wrong");

    property p_spacing;
        cmdFire |-> ##[1:2] !cmdPend;
    endproperty
    a_spacing: assert property (p_spacing) else $error("commands too close");

endmodule

// *** bench/ccs_engine_model.sv ***
/*
 Stand-in for the protocol engine and the bus beyond it.
 Assumes the same clock as the block; receive side levels come from the bench.
*/
`timescale 1ns/1ns
module ccs_engine_model (
    // Clock and reset
    input  wire logic                 clock,
    input  wire logic                 arst_n,
    // Requests and bench controls
    input  wire ccs_pkg::ccs_txctl_t  txCtl,
    input  wire logic [7:0]           gap,
    input  wire logic                 fail,
    input  wire ccs_pkg::ccs_engine_t rxSide,
    // Engine view
    output      ccs_pkg::ccs_engine_t engine
);
    import ccs_pkg::*;
    localparam logic [7:0] FRAME_LEN = 8'h06;
    logic [7:0] count;
    logic       running;
    logic       frameEnd;

    // ==========================================
    // Frame timing: wait gap, then a fixed frame
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            count <= 8'h00;
            running <= 1'b0;
            frameEnd <= 1'b0;
        end else begin
            frameEnd <= 1'b0;
            count <= 8'h00;
            if (running) begin
                count <= count + 8'h01;
                if (count == FRAME_LEN) begin
                    running <= 1'b0;
                    frameEnd <= 1'b1;
                end
            end else if (txCtl.txGo) begin
                count <= count + 8'h01;
                if (count >= gap) begin
                    running <= 1'b1;
                    count <= 8'h00;
                end
            end
        end
    end

    // Qualifier is junk outside the end pulse
    always_comb begin
        engine = rxSide;
        engine.txActive = running;
        engine.txFrameEnd = frameEnd;
        engine.txFrameOk = frameEnd ? !fail : count[0];
    end
endmodule

// *** bench/test_can_command_status_logic.sv ***
/*
 Self-checking bench for the command and status logic.
 Assumes ccs_pkg and the engine stand-in are compiled first.
*/
`timescale 1ns/1ns
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module test_can_command_status_logic;
    import ccs_pkg::*;
    logic        clock = 1'b0, arst_n = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, gap = 8'h00, st, te, re;
    logic [31:0] wdata = 32'h0, seed = 32'hE46B, rdata;
    logic [3:0]  wstrb = 4'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        hostBufWe = 1'b0, fail = 1'b0, bo, ra;
    logic        awready, wready, bvalid, arready, rvalid, rxRelease, txEvent, overrunEvent;
    logic        rxPendingFlag, txBufWe;
    logic [1:0]  bresp, rresp, resp;
    ccs_engine_t rxSide = '0, engine;
    ccs_txctl_t  txCtl;
    int          num_errors = 0, num_checks = 0, nTx = 0, nOvr = 0, nRel = 0, nFrm = 0, base;
    logic [7:0]  pats [6] = '{8'h01, 8'h11, 8'h03, 8'h13, 8'h10, 8'h12};

    always #5 clock = ~clock;

    can_command_status_logic i_can_command_status_logic (.clock(clock), .arst_n(arst_n),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .engine(engine), .txCtl(txCtl), .rxRelease(rxRelease),
        .txEvent(txEvent), .overrunEvent(overrunEvent), .rxPendingFlag(rxPendingFlag),
        .hostBufWe(hostBufWe), .txBufWe(txBufWe));
    ccs_engine_model i_ccs_engine_model (.clock(clock), .arst_n(arst_n), .txCtl(txCtl),
        .gap(gap), .fail(fail), .rxSide(rxSide), .engine(engine));

    always @(posedge clock) begin
        nTx <= nTx + int'(txEvent);
        nOvr <= nOvr + int'(overrunEvent);
        nRel <= nRel + int'(rxRelease);
        nFrm <= nFrm + int'(engine.txFrameEnd);
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    function automatic logic [7:0] expState(input logic b, r, input logic [7:0] t, x, lim);
        return {b, (t >= lim) || (x >= lim), 1'b0, r, 4'hC};
    endfunction

    // ==========================================
    // Bus tasks; one write at a time spaces commands
    task automatic axiWr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
        logic aw, w, b;
        @(posedge clock);
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(negedge clock);
            aw = awvalid && awready;
            w = wvalid && wready;
            b = bvalid;
            r = bresp;
            @(posedge clock);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
            if (b) begin
                bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic axiRd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
        logic ar, v;
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(negedge clock);
            ar = arvalid && arready;
            v = rvalid;
            d = rdata[7:0];
            r = rresp;
            @(posedge clock);
            if (ar) arvalid <= 1'b0;
            if (v) begin
                rready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic cmd(input logic [7:0] d);
        axiWr({CCS_IDX_CMD, 2'b00}, d, resp);
    endtask

    task automatic chkState(input logic [7:0] e);
        axiRd({CCS_IDX_STATE, 2'b00}, st, resp);
        `CHK("state", e, st)
    endtask

    task automatic waitTx(input int n);
        for (int k = 0; k < 300 && nTx < n; k++) @(negedge clock);
    endtask

    task automatic waitAct();
        for (int k = 0; k < 300 && !engine.txActive; k++) @(negedge clock);
    endtask

    task automatic bufTry(input logic e);
        @(posedge clock);
        hostBufWe <= 1'b1;
        @(posedge clock);
        hostBufWe <= 1'b0;
        @(negedge clock);
        `CHK("bufWe", e, txBufWe)
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        num_errors++;
        summarize();
    end

    // ==========================================
    // Main sequence
    initial begin
        repeat (10) @(posedge clock);
        arst_n <= 1'b1;
        chkState(8'h0C);
        axiRd({CCS_IDX_WARN, 2'b00}, st, resp);
        `CHK("limit", 8'h60, st)
        cmd(8'h00);
        axiRd({CCS_IDX_CMD, 2'b00}, st, resp);
        `CHK("cmdRead", 8'h00, st)
        axiRd(8'h1C, st, resp);
        `CHK("rdResp", CCS_RESP_SLVER, resp)
        axiWr(8'h1C, 8'h01, resp);
        `CHK("wrResp", CCS_RESP_SLVER, resp)
        bufTry(1'b1);
        foreach (pats[i]) begin
            gap <= 8'h1E;
            base = nTx;
            cmd(pats[i]);
            @(negedge clock);
            `CHK("txGo", 1'b1, txCtl.txGo)
            `CHK("selfRx", pats[i][4] & ~pats[i][0], txCtl.selfRx)
            `CHK("single", pats[i][1], txCtl.singleShot)
            chkState(8'h00);
            bufTry(1'b0);
            waitAct();
            @(negedge clock);
            `CHK("txGoDrop", 1'b0, txCtl.txGo)
            waitTx(base + 1);
            chkState(8'h0C);
        end
        base = nTx;
        cmd(8'h01);
        cmd(8'h00);
        @(negedge clock);
        `CHK("txGoHeld", 1'b1, txCtl.txGo)
        cmd(8'h02);
        @(negedge clock);
        `CHK("txGoAbort", 1'b0, txCtl.txGo)
        `CHK("abortEvent", base + 1, nTx)
        chkState(8'h04);
        gap <= 8'h02;
        base = nFrm;
        cmd(8'h01);
        waitAct();
        cmd(8'h02);
        waitTx(nTx + 1);
        `CHK("frameRan", base + 1, nFrm)
        chkState(8'h0C);
        fail <= 1'b1;
        base = nFrm;
        cmd(8'h01);
        for (int k = 0; k < 300 && nFrm == base; k++) @(negedge clock);
        fail <= 1'b0;
        waitTx(nTx + 1);
        `CHK("retry", base + 2, nFrm)
        fail <= 1'b1;
        base = nFrm;
        cmd(8'h03);
        waitTx(nTx + 1);
        `CHK("oneShot", base + 1, nFrm)
        chkState(8'h04);
        fail <= 1'b0;
        for (int i = 0; i < 2; i++) begin
            @(posedge clock);
            rxSide.rxNoSpace <= 1'b1;
            @(posedge clock);
            rxSide.rxNoSpace <= 1'b0;
            chkState(8'h06);
        end
        `CHK("ovrEvents", 1, nOvr)
        cmd(8'h00);
        chkState(8'h06);
        cmd(8'h08);
        chkState(8'h04);
        for (int i = 0; i < 2; i++) begin
            @(posedge clock);
            rxSide.rxMsgStored <= 1'b1;
            @(posedge clock);
            rxSide.rxMsgStored <= 1'b0;
        end
        chkState(8'h05);
        cmd(8'h04);
        @(negedge clock);
        `CHK("pendKeep", 1'b1, rxPendingFlag)
        cmd(8'h04);
        cmd(8'h04);
        `CHK("released", 2, nRel)
        chkState(8'h04);
        axiWr({CCS_IDX_WARN, 2'b00}, 8'h50, resp);
        for (int i = 0; i < 10; i++) begin
            seed = xs(seed);
            {bo, ra, te, re} = seed[17:0];
            if (i == 0) te = 8'h50;
            if (i == 1) {te, re} = 16'h4F4F;
            @(posedge clock);
            rxSide.busOff <= bo;
            rxSide.rxActive <= ra;
            rxSide.txErrCount <= te;
            rxSide.rxErrCount <= re;
            repeat (2) @(posedge clock);
            chkState(expState(bo, ra, te, re, 8'h50) & 8'hF4);
        end
        summarize();
    end
endmodule
